// ---- common/core_pkg.sv ----
// Shared constants, field layouts and carriers of the datapath core.
package core_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int DATA_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int ADDR_W    = 5;
    localparam int RAM_DEPTH = 32;
    localparam int STAT_W    = 8;
    localparam int FLAG_W    = 4;
    localparam int COND_N    = 12;
    localparam int SEL_W     = 4;

    // ------------------------------------------------------------------
    // Opcode field values
    // ------------------------------------------------------------------
    localparam logic [3:0] OPC_NOP   = 4'h0;
    localparam logic [3:0] OPC_PASS  = 4'h1;
    localparam logic [3:0] OPC_ADD   = 4'h2;
    localparam logic [3:0] OPC_SUB   = 4'h3;
    localparam logic [3:0] OPC_AND   = 4'h4;
    localparam logic [3:0] OPC_OR    = 4'h5;
    localparam logic [3:0] OPC_XOR   = 4'h6;
    localparam logic [3:0] OPC_NOT   = 4'h7;
    localparam logic [3:0] OPC_IMM   = 4'h8;
    localparam logic [3:0] OPC_SAVE  = 4'h9;
    localparam logic [3:0] OPC_TEST  = 4'hA;
    localparam logic [3:0] OPC_LDST  = 4'hB;

    // Source and destination field values.
    localparam logic [1:0] SRC_RAM   = 2'h0;
    localparam logic [1:0] SRC_ACC   = 2'h1;
    localparam logic [1:0] SRC_LATCH = 2'h2;
    localparam logic [1:0] SRC_ZERO  = 2'h3;
    localparam logic [1:0] DST_NONE  = 2'h0;
    localparam logic [1:0] DST_RAM   = 2'h1;
    localparam logic [1:0] DST_ACC   = 2'h2;
    localparam logic [1:0] DST_BUS   = 2'h3;

    // Status word bit positions.
    localparam int ST_Z    = 0;
    localparam int ST_C    = 1;
    localparam int ST_N    = 2;
    localparam int ST_V    = 3;
    localparam int ST_LINK = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]        op;
        logic [1:0]        src;
        logic [1:0]        dst;
        logic              byte_mode;
        logic [1:0]        spare;
        logic [ADDR_W-1:0] addr;
    } instr_type;

    typedef struct packed {
        logic v;
        logic n;
        logic c;
        logic z;
    } alu_flags_type;

endpackage

// ---- hw/working_store.sv ----
// Single-port 32x16 working RAM with clock-following output latch.
`timescale 1ns/1ps
module working_store
    import core_pkg::*;
#(
    parameter int DW    = DATA_W,
    parameter int AW    = ADDR_W,
    parameter int DEPTH = RAM_DEPTH
) (
    input  wire logic          clk_in,
    input  wire logic          arst_n_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic          wr_en_in,
    input  wire logic          byte_mode_in,
    input  wire logic [DW-1:0] wr_data_in,
    output logic      [DW-1:0] rd_data_out
);

    logic [DW-1:0] mem_reg [DEPTH];
    logic [DW-1:0] latch_reg;

    // Output latch holds across the low phase while writes happen.
    always_ff @(negedge clk_in) begin
        latch_reg <= mem_reg[addr_in];
    end

    assign rd_data_out = clk_in ? mem_reg[addr_in] : latch_reg;

    // The write closes at the end of the low phase; byte mode spares
    // the upper byte.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[addr_in][BYTE_W-1:0] <= wr_data_in[BYTE_W-1:0];
            if (!byte_mode_in) begin
                mem_reg[addr_in][DW-1:BYTE_W] <= wr_data_in[DW-1:BYTE_W];
            end
        end
    end

    logic [DW-1:0] word_now;
    assign word_now = mem_reg[addr_in];

    a_ram_byte_keep: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        wr_en_in && byte_mode_in |=>
        mem_reg[$past(addr_in)] ==
        {$past(word_now[DW-1:BYTE_W]), $past(wr_data_in[BYTE_W-1:0])})
        else $error("byte write altered the upper byte");

endmodule

// ---- hw/condition_select.sv ----
// Twelve-way condition generator and selector for the test output.
`timescale 1ns/1ps
module condition_select
    import core_pkg::*;
(
    input  wire logic [FLAG_W-1:0] flags_in,
    input  wire logic [SEL_W-1:0]  sel_in,
    input  wire logic              sel_valid_in,
    output logic                   pass_out
);

    alu_flags_type f;
    logic          lt;
    logic          le;
    logic [COND_N-1:0] cond;

    assign f  = alu_flags_type'(flags_in);
    assign lt = f.n ^ f.v;
    assign le = lt | f.z;

    // Even codes test a condition, odd codes its complement.
    genvar g;
    generate
        for (g = 0; g < COND_N / 2; g++) begin : g_pair
            logic base;
            assign base = (g == 0) ? f.z : (g == 1) ? f.c :
                          (g == 2) ? f.n : (g == 3) ? f.v :
                          (g == 4) ? lt  : le;
            assign cond[2*g]   = base;
            assign cond[2*g+1] = ~base;
        end
    endgenerate

    assign pass_out = sel_valid_in && (sel_in < SEL_W'(COND_N)) &&
                      cond[sel_in];

endmodule

// ---- hw/microcoded_datapath_core.sv ----
// Microprogrammed 16-bit datapath slice: RAM, accumulator, latches.
`timescale 1ns/1ps
module microcoded_datapath_core
    import core_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = ADDR_W
) (
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [DW-1:0]     instruction_inputs_in,
    input  wire logic              instruction_enable_n_in,
    input  wire logic              status_update_en_n_in,
    input  wire logic              input_latch_open_in,
    input  wire logic              data_bus_drive_en_n_in,
    input  wire logic              flag_bus_drive_en_in,
    input  wire logic [DW-1:0]     data_io_lines_in,
    output logic      [DW-1:0]     data_io_lines_out,
    output logic                   data_io_lines_oe_n_out,
    input  wire logic [FLAG_W-1:0] flag_io_lines_in,
    output logic      [FLAG_W-1:0] flag_io_lines_out,
    output logic                   flag_io_lines_oe_n_out,
    output logic                   condition_test_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [DW-1:0]     data_meta_reg;
    logic [DW-1:0]     data_sync_reg;
    logic [FLAG_W-1:0] flag_meta_reg;
    logic [FLAG_W-1:0] flag_sync_reg;
    logic              open_meta_reg;
    logic              open_sync_reg;
    logic              latch_seen_reg;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            latch_seen_reg <= 1'b0;
            data_meta_reg <= '0;
            data_sync_reg <= '0;
            flag_meta_reg <= '0;
            flag_sync_reg <= '0;
            open_meta_reg <= 1'b0;
            open_sync_reg <= 1'b0;
        end else begin
            latch_seen_reg <= latch_seen_reg | open_sync_reg;
            data_meta_reg <= data_io_lines_in;
            data_sync_reg <= data_meta_reg;
            flag_meta_reg <= flag_io_lines_in;
            flag_sync_reg <= flag_meta_reg;
            open_meta_reg <= input_latch_open_in;
            open_sync_reg <= open_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Input data latch
    // ------------------------------------------------------------------
    logic [DW-1:0] data_latch_reg;

    // Holds power-up garbage until first opened.
    always_ff @(posedge clk_in) begin
        if (open_sync_reg) begin
            data_latch_reg <= data_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // Instruction latch and immediate sequencing
    // ------------------------------------------------------------------
    typedef enum logic {
        IMM_IDLE,
        IMM_OPERAND
    } imm_state_type;

    imm_state_type imm_state_reg;
    imm_state_type imm_state_next;
    logic [DW-1:0] instr_latch_reg;
    instr_type     instr;
    logic          enable;
    logic          imm_first;
    logic          imm_second;

    assign enable     = !instruction_enable_n_in;
    assign imm_second = (imm_state_reg == IMM_OPERAND);
    // Transparent except during the operand cycle of an immediate.
    assign instr      = instr_type'(imm_second ? instr_latch_reg
                                               : instruction_inputs_in);
    assign imm_first  = enable && !imm_second && (instr.op == OPC_IMM);

    always_comb begin
        imm_state_next = imm_state_reg;
        case (imm_state_reg)
            IMM_IDLE: begin
                if (imm_first) begin
                    imm_state_next = IMM_OPERAND;
                end
            end
            IMM_OPERAND: begin
                imm_state_next = IMM_IDLE;
            end
            default: begin
                imm_state_next = IMM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            imm_state_reg <= IMM_IDLE;
        end else begin
            imm_state_reg <= imm_state_next;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            instr_latch_reg <= '0;
        end else if (imm_first) begin
            instr_latch_reg <= instruction_inputs_in;
        end
    end

    // ------------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------------
    logic [DW-1:0] ram_rd;
    logic [DW-1:0] acc_reg;
    logic [DW-1:0] opa;
    logic [DW-1:0] opb;
    logic [3:0]    fn;

    // An immediate takes its operand from the second cycle's inputs and
    // its function from the source field of the first word.
    always_comb begin
        opb = acc_reg;
        fn  = instr.op;
        case (instr.src)
            SRC_RAM:   opa = ram_rd;
            SRC_ACC:   opa = acc_reg;
            SRC_LATCH: opa = data_latch_reg;
            default:   opa = '0;
        endcase
        if (imm_second) begin
            opa = instruction_inputs_in;
            case (instr.src)
                2'h0:    fn = OPC_PASS;
                2'h1:    fn = OPC_ADD;
                2'h2:    fn = OPC_AND;
                default: fn = OPC_OR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Arithmetic and logic
    // ------------------------------------------------------------------
    logic [DW:0]     sum_w;
    logic [BYTE_W:0] sum_b;
    logic [DW-1:0]   addb;
    logic            cin;
    logic [DW-1:0]   result;
    alu_flags_type   flags;
    logic [STAT_W-1:0] status_reg;
    logic              is_arith;
    logic              msb;
    logic              amsb;
    logic              bmsb;

    assign cin   = (fn == OPC_SUB);
    assign addb  = (fn == OPC_SUB) ? ~opb : opb;
    assign sum_w = {1'b0, opa} + {1'b0, addb} + {{DW{1'b0}}, cin};
    assign sum_b = {1'b0, opa[BYTE_W-1:0]} + {1'b0, addb[BYTE_W-1:0]}
                 + {{BYTE_W{1'b0}}, cin};
    assign is_arith = (fn == OPC_ADD) || (fn == OPC_SUB);

    always_comb begin
        case (fn)
            OPC_ADD,
            OPC_SUB: result = sum_w[DW-1:0];
            OPC_AND: result = opa & opb;
            OPC_OR:  result = opa | opb;
            OPC_XOR: result = opa ^ opb;
            OPC_NOT: result = ~opa;
            OPC_SAVE: result = {{(DW-STAT_W){1'b0}}, status_reg};
            default: result = opa;
        endcase
    end

    // Flags are formed at byte or word level as the mode asks.
    always_comb begin
        if (instr.byte_mode) begin
            msb     = result[BYTE_W-1];
            amsb    = opa[BYTE_W-1];
            bmsb    = addb[BYTE_W-1];
            flags.z = (result[BYTE_W-1:0] == '0);
            flags.c = is_arith && sum_b[BYTE_W];
        end else begin
            msb     = result[DW-1];
            amsb    = opa[DW-1];
            bmsb    = addb[DW-1];
            flags.z = (result == '0);
            flags.c = is_arith && sum_w[DW];
        end
        flags.n = msb;
        flags.v = is_arith && (amsb == bmsb) && (msb != amsb);
    end

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    logic exec;
    logic wr_ram;
    logic wr_acc;
    logic st_upd;

    // The first cycle of an immediate only captures the instruction.
    assign exec   = enable && !imm_first && (instr.op != OPC_NOP)
                  && (instr.op != OPC_TEST);
    assign wr_ram = exec && (instr.dst == DST_RAM);
    assign wr_acc = exec && (instr.dst == DST_ACC);
    assign st_upd = enable && !status_update_en_n_in && !imm_first
                  && (instr.op != OPC_NOP) && (instr.op != OPC_SAVE)
                  && (instr.op != OPC_TEST);

    // ------------------------------------------------------------------
    // Working store
    // ------------------------------------------------------------------
    working_store #(
        .DW    (DW),
        .AW    (AW),
        .DEPTH (RAM_DEPTH)
    ) u_store (
        .clk_in       (clk_in),
        .arst_n_in    (arst_n_in),
        .addr_in      (instr.addr),
        .wr_en_in     (wr_ram),
        .byte_mode_in (instr.byte_mode),
        .wr_data_in   (result),
        .rd_data_out  (ram_rd)
    );

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (wr_acc) begin
            acc_reg[BYTE_W-1:0] <= result[BYTE_W-1:0];
            if (!instr.byte_mode) begin
                acc_reg[DW-1:BYTE_W] <= result[DW-1:BYTE_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    // Layout: user flags 3..1, link, overflow, negative, carry, zero.
    always_ff @(posedge clk_in) begin
        if (st_upd) begin
            if (instr.op == OPC_LDST) begin
                status_reg[FLAG_W-1:0] <= result[FLAG_W-1:0];
                if (!instr.byte_mode) begin
                    status_reg[STAT_W-1:FLAG_W] <=
                        result[STAT_W-1:FLAG_W];
                end
            end else begin
                status_reg[FLAG_W-1:0] <= flags;
            end
        end
    end

    // ------------------------------------------------------------------
    // Result bus and flag bus
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_io_lines_out <= '0;
        end else if (exec) begin
            data_io_lines_out <= result;
        end
    end

    assign data_io_lines_oe_n_out = data_bus_drive_en_n_in;
    assign flag_io_lines_oe_n_out = !flag_bus_drive_en_in;
    assign flag_io_lines_out      = status_reg[FLAG_W-1:0];

    // ------------------------------------------------------------------
    // Conditional test
    // ------------------------------------------------------------------
    logic [SEL_W-1:0] cond_sel;
    logic             cond_valid;
    logic             test_instr;

    // A test instruction outranks the flag lines as selector.
    assign test_instr = enable && !imm_second && (instr.op == OPC_TEST);
    assign cond_sel   = test_instr ? instr.addr[SEL_W-1:0]
                                   : flag_sync_reg;
    assign cond_valid = test_instr || !flag_bus_drive_en_in;

    condition_select u_cond (
        .flags_in     (status_reg[FLAG_W-1:0]),
        .sel_in       (cond_sel),
        .sel_valid_in (cond_valid),
        .pass_out     (condition_test_out)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_acc_word_load: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        wr_acc && !instr.byte_mode |=> acc_reg == $past(result))
        else $error("accumulator missed a word load");

    a_acc_byte_keep: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        wr_acc && instr.byte_mode |=>
        acc_reg == {$past(acc_reg[DW-1:BYTE_W]),
                    $past(result[BYTE_W-1:0])})
        else $error("byte load disturbed accumulator upper byte");

    a_acc_enable_hold: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        instruction_enable_n_in |=> $stable(acc_reg))
        else $error("accumulator changed while disabled");

    a_status_freeze: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (instruction_enable_n_in || status_update_en_n_in) |=>
        $stable(status_reg))
        else $error("status changed while frozen");

    a_status_flags: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        st_upd && is_arith |=>
        status_reg[FLAG_W-1:0] == $past(flags) &&
        $stable(status_reg[STAT_W-1:FLAG_W]))
        else $error("status did not take the arithmetic flags");

    a_imm_two_cycle: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        imm_first |=> imm_second ##1 !imm_second)
        else $error("immediate did not span exactly two cycles");

    a_imm_no_store: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        imm_first |-> !wr_ram && !st_upd)
        else $error("first immediate cycle wrote state");

    a_latch_follow: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        open_sync_reg |=> data_latch_reg == $past(data_sync_reg))
        else $error("input latch did not follow the bus");

    a_latch_hold: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        latch_seen_reg && !open_sync_reg ##1 !open_sync_reg |->
        $stable(data_latch_reg))
        else $error("closed input latch changed");

    a_ct_disabled: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        instruction_enable_n_in && flag_bus_drive_en_in |->
        !condition_test_out)
        else $error("test output driven by instruction while disabled");

endmodule

// ---- dv/far_side_model.sv ----
// Far-side model: system bus and flag bus seen from outside the core.
`timescale 1ns/1ps
module far_side_model
    import core_pkg::*;
(
    input  wire logic [DATA_W-1:0] bus_value_in,
    input  wire logic [FLAG_W-1:0] test_sel_in,
    input  wire logic [DATA_W-1:0] dev_data_in,
    input  wire logic              dev_data_oe_n_in,
    input  wire logic [FLAG_W-1:0] dev_flag_in,
    input  wire logic              dev_flag_oe_n_in,
    output logic      [DATA_W-1:0] data_wire_out,
    output logic      [FLAG_W-1:0] flag_wire_out
);
    // The far side only drives a wire that the core has released.
    assign data_wire_out = dev_data_oe_n_in ? bus_value_in : dev_data_in;
    assign flag_wire_out = dev_flag_oe_n_in ? test_sel_in : dev_flag_in;
endmodule

// ---- dv/tb_microcoded_datapath_core.sv ----
// Self-checking testbench of the microcoded datapath core.
`timescale 1ns/1ps
module tb_microcoded_datapath_core
    import core_pkg::*;
;
    logic        clk = 0, arst_n = 0, en_n = 0, sre_n = 0;
    logic        input_latch_open = 0, oey_n = 1, flag_bus_drive_en = 0, ct;
    logic [15:0] instr = 16'h0000, bus_val = 16'h0000, dout, dwire;
    logic [3:0]  tsel = 4'h0, fout, fwire;
    logic        doe_n, foe_n;
    int          num_errors = 0, comparisons = 0;

    microcoded_datapath_core u_dut (.clk_in(clk), .arst_n_in(arst_n),
        .instruction_inputs_in(instr), .instruction_enable_n_in(en_n),
        .status_update_en_n_in(sre_n), .input_latch_open_in(input_latch_open),
        .data_bus_drive_en_n_in(oey_n), .flag_bus_drive_en_in(flag_bus_drive_en),
        .data_io_lines_in(dwire), .data_io_lines_out(dout),
        .data_io_lines_oe_n_out(doe_n), .flag_io_lines_in(fwire),
        .flag_io_lines_out(fout), .flag_io_lines_oe_n_out(foe_n),
        .condition_test_out(ct));
    far_side_model u_far (.bus_value_in(bus_val), .test_sel_in(tsel),
        .dev_data_in(dout), .dev_data_oe_n_in(doe_n), .dev_flag_in(fout),
        .dev_flag_oe_n_in(foe_n), .data_wire_out(dwire),
        .flag_wire_out(fwire));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [15:0] mk(logic [3:0] o, logic [1:0] s,
                                       logic [1:0] d, logic b, logic [4:0] a);
        return {o, s, d, b, 2'h0, a};
    endfunction

    // Applies one microword at the falling edge; it executes at the next rise.
    // Enable stays low through both immediate cycles, and one address
    // field serves read and write alike.
    task automatic run(input logic [15:0] w, input logic e = 1'b0);
        @(negedge clk);
        instr = w;
        en_n = e;
    endtask

    // Moves a source onto the result register and compares it.
    task automatic show(input logic [1:0] s, input logic [4:0] a,
                        input logic [15:0] exp);
        run(mk(OPC_PASS, s, DST_BUS, 1'b0, a));
        run(16'h0000);
        check(dout, exp);
    endtask

    task automatic t_acc;
        run(mk(OPC_IMM, 2'h0, DST_ACC, 1'b0, 5'h00));
        run(16'h1234);
        show(SRC_ACC, 5'h00, 16'h1234);
        run(mk(OPC_IMM, 2'h0, DST_ACC, 1'b1, 5'h00));
        run(16'hFFAB);
        show(SRC_ACC, 5'h00, 16'h12AB);
        run(mk(OPC_PASS, SRC_ZERO, DST_ACC, 1'b0, 5'h00), 1'b1);
        show(SRC_ACC, 5'h00, 16'h12AB);
        $display("test accumulator done");
    endtask

    task automatic t_ram;
        run(mk(OPC_PASS, SRC_ACC, DST_RAM, 1'b0, 5'h1F));
        run(mk(OPC_PASS, SRC_ZERO, DST_RAM, 1'b0, 5'h1F), 1'b1);
        show(SRC_RAM, 5'h1F, 16'h12AB);
        run(mk(OPC_PASS, SRC_ACC, DST_RAM, 1'b0, 5'h07));
        run(mk(OPC_IMM, 2'h0, DST_RAM, 1'b1, 5'h07));
        run(16'h55CD);
        show(SRC_RAM, 5'h07, 16'h12CD);
        $display("test ram done");
    endtask

    task automatic t_status;
        logic [15:0] tab;
        tab = 16'h06A9;
        flag_bus_drive_en = 1'b1;
        run(mk(OPC_AND, SRC_ZERO, DST_NONE, 1'b0, 5'h00));
        run(16'h0000);
        check({12'h000, fout}, 16'h0001);
        check({15'h0, foe_n}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            if (i != 11) begin
                run(mk(OPC_TEST, 2'h0, 2'h0, 1'b0, 5'(i)));
                #1 check({15'h0, ct}, {15'h0, tab[i]});
            end
        end
        run(mk(OPC_TEST, 2'h0, 2'h0, 1'b0, 5'h00), 1'b1);
        #1 check({15'h0, ct}, 16'h0000);
        sre_n = 1'b1;
        run(mk(OPC_PASS, SRC_ACC, DST_NONE, 1'b0, 5'h00));
        run(16'h0000);
        check({12'h000, fout}, 16'h0001);
        sre_n = 1'b0;
        run(mk(OPC_PASS, SRC_ACC, DST_NONE, 1'b0, 5'h00));
        run(16'h0000);
        check({12'h000, fout}, 16'h0000);
        flag_bus_drive_en = 1'b0;
        tsel = 4'h1;
        run(16'h0000, 1'b1);
        repeat (4) @(negedge clk);
        check({15'h0, foe_n}, 16'h0001);
        check({15'h0, ct}, 16'h0001);
        $display("test status done");
    endtask

    task automatic t_latch;
        bus_val = 16'hBEEF;
        input_latch_open = 1'b1;
        repeat (5) @(negedge clk);
        check({15'h0, doe_n}, 16'h0001);
        input_latch_open = 1'b0;
        repeat (4) @(negedge clk);
        bus_val = 16'h0F0F;
        repeat (5) @(negedge clk);
        oey_n = 1'b0;
        show(SRC_LATCH, 5'h00, 16'hBEEF);
        check({15'h0, doe_n}, 16'h0000);
        check(dwire, 16'hBEEF);
        $display("test latch done");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        t_acc;
        t_ram;
        t_status;
        t_latch;
        wrap_up;
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
endmodule
